// >>> verilog/simd_pkg.sv
// Constants, types and opcodes for the dual-element SIMD datapath.
// Assumes one core clock and an instruction stream from the program sequencer.
// Function
// - The primary element always executes, whatever the mode.
// - The secondary element runs only while the second-element enable bit is set.
// - In SIMD mode each instruction goes to both elements, each on its own operands.
// - In SIMD mode every memory or register access moves two values, one per element.
// - The ALU and one of multiplier or shifter work in parallel and finish in one cycle.
// - A multifunction instruction does an ALU and a multiply together, in both elements in SIMD mode.
// - Each element has a 32-register file: 16 primary and 16 secondary.
// - Units handle 32-bit float, 40-bit extended float and 32-bit fixed formats.
package simd_pkg;
  localparam int DATA_W = 40;
  localparam int REG_AW = 4;
  localparam int NUM_ELEM = 2;
  localparam int NUM_BANKS = 2;
  localparam int REGS_PER_BANK = 16;
  localparam int FILE_AW = 5;
  localparam logic [DATA_W-1:0] REG_RESET = 40'h00_0000_0000;
  localparam int FIX_W = 32;
  localparam int EXP_LSB = 31;
  localparam int SHAMT_W = 6;
  localparam logic [DATA_W-1:0] FIX_MASK = 40'h00_FFFF_FFFF;
  localparam logic [DATA_W-1:0] SP_MASK = 40'hFF_FFFF_FF00;

  typedef enum logic [1:0] {
    FMT_FIXED = 2'h0,
    FMT_SINGLE = 2'h1,
    FMT_EXTENDED = 2'h2
  } fmt_t;

  typedef enum logic [2:0] {
    ALU_NOP = 3'h0,
    ALU_ADD = 3'h1,
    ALU_SUB = 3'h2,
    ALU_AND = 3'h3,
    ALU_OR = 3'h4,
    ALU_XOR = 3'h5,
    ALU_PASS = 3'h6
  } alu_op_t;

  typedef enum logic [1:0] {
    SEC_NONE = 2'h0,
    SEC_MUL = 2'h1,
    SEC_SHL = 2'h2,
    SEC_SHR = 2'h3
  } sec_op_t;

  typedef struct packed {
    alu_op_t alu_op;
    sec_op_t sec_op;
    fmt_t fmt;
    logic alt_bank;
    logic [REG_AW-1:0] src_a;
    logic [REG_AW-1:0] src_b;
    logic [REG_AW-1:0] alu_dst;
    logic [REG_AW-1:0] sec_dst;
    logic [SHAMT_W-1:0] shamt;
  } instr_t;

  typedef struct packed {
    logic wr_en;
    logic [REG_AW-1:0] addr;
    logic [DATA_W-1:0] data;
  } mem_xfer_t;

  typedef struct packed {
    logic [DATA_W-1:0] x;
    logic [DATA_W-1:0] y;
  } pair_t;
endpackage

// >>> verilog/elem_regfile.sv
// Multi-port data register file of one processing element, two banks of 16.
// Assumes at most three writes per cycle to distinct addresses; later port wins on clash.
module elem_regfile
  import simd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [FILE_AW-1:0] rd_a_addr,
  input wire logic [FILE_AW-1:0] rd_b_addr,
  input wire logic [FILE_AW-1:0] rd_m_addr,
  output logic [DATA_W-1:0] rd_a_data,
  output logic [DATA_W-1:0] rd_b_data,
  output logic [DATA_W-1:0] rd_m_data,
  input wire logic [2:0] wr_en,
  input wire logic [FILE_AW-1:0] wr_addr [3],
  input wire logic [DATA_W-1:0] wr_data [3]
);
  localparam int DEPTH = NUM_BANKS * REGS_PER_BANK;
  logic [DATA_W-1:0] mem_q [DEPTH];

  // Storage: each word checks the three write ports, highest index last
  for (genvar i = 0; i < DEPTH; i++) begin : g_word
    always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
        mem_q[i] <= REG_RESET;
      end else begin
        for (int p = 0; p < 3; p++) begin
          if (wr_en[p] && wr_addr[p] == FILE_AW'(i)) begin
            mem_q[i] <= wr_data[p];
          end
        end
      end
    end
  end

  // Read ports are registered so data leave from flip-flops
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rd_a_data <= REG_RESET;
      rd_b_data <= REG_RESET;
      rd_m_data <= REG_RESET;
    end else begin
      rd_a_data <= mem_q[rd_a_addr];
      rd_b_data <= mem_q[rd_b_addr];
      rd_m_data <= mem_q[rd_m_addr];
    end
  end
endmodule

// >>> verilog/simd_datapath.sv
// Dual processing-element SIMD datapath: two register files, ALU/multiplier/shifter each.
// Assumes the sequencer holds operands one cycle: reads register, then compute and write.
module simd_datapath
  import simd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic second_element_enable,
  input wire logic instr_valid,
  input instr_t instr,
  input mem_xfer_t mem_xfer,
  input wire logic mem_xfer_valid,
  input pair_t mem_wr_pair,
  output pair_t mem_rd_pair,
  output logic mem_rd_pair_valid,
  output pair_t alu_result,
  output pair_t sec_result,
  output logic result_valid,
  output logic simd_active
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_EXEC = 2'b11
  } stage_t;

  stage_t stage_q, stage_d;
  instr_t instr_q;
  logic simd_q;
  logic mem_rd_q;
  mem_xfer_t xfer_q;
  logic xfer_pend_q;

  // Register file address: bank bit above the 4-bit index
  function automatic logic [FILE_AW-1:0] reg_addr(input logic bank, input logic [REG_AW-1:0] idx);
    return {bank, idx};
  endfunction

  // Format-aware ALU, all single-cycle combinational logic
  function automatic logic [DATA_W-1:0] alu_fn(input alu_op_t op, input fmt_t fmt,
                                               input logic [DATA_W-1:0] a,
                                               input logic [DATA_W-1:0] b);
    logic [DATA_W-1:0] r;
    r = '0;
    case (op)
      ALU_ADD: r = a + b;
      ALU_SUB: r = a - b;
      ALU_AND: r = a & b;
      ALU_OR: r = a | b;
      ALU_XOR: r = a ^ b;
      ALU_PASS: r = a;
      default: r = '0;
    endcase
    // Narrow formats drop bits beyond their width; arithmetic kept integer-style
    case (fmt)
      FMT_FIXED: r = r & FIX_MASK;
      FMT_SINGLE: r = r & SP_MASK;
      default: r = r;
    endcase
    return r;
  endfunction

  // Multiplier or shifter in parallel with the ALU
  function automatic logic [DATA_W-1:0] sec_fn(input sec_op_t op, input fmt_t fmt,
                                               input logic [DATA_W-1:0] a,
                                               input logic [DATA_W-1:0] b,
                                               input logic [SHAMT_W-1:0] sh);
    logic [2*FIX_W-1:0] prod;
    logic [DATA_W-1:0] r;
    prod = a[FIX_W-1:0] * b[FIX_W-1:0];
    r = '0;
    case (op)
      SEC_MUL: r = (fmt == FMT_FIXED) ? {{(DATA_W-FIX_W){1'b0}}, prod[FIX_W-1:0]}
                                      : prod[DATA_W-1:0];
      SEC_SHL: r = a << sh;
      SEC_SHR: r = a >> sh;
      default: r = '0;
    endcase
    return r;
  endfunction

  // Pipeline control: read stage then execute stage
  always_comb begin
    case (stage_q)
      ST_IDLE: stage_d = instr_valid ? ST_READ : ST_IDLE;
      ST_READ: stage_d = ST_EXEC;
      ST_EXEC: stage_d = instr_valid ? ST_READ : ST_IDLE;
      default: stage_d = ST_IDLE;
    endcase
  end

  wire take_instr = instr_valid && (stage_q != ST_READ);
  wire exec_now = (stage_q == ST_EXEC);

  // Mode sampled with each instruction so a mid-flight change cannot split it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stage_q <= ST_IDLE;
      instr_q <= '0;
      simd_q <= 1'b0;
    end else begin
      stage_q <= stage_d;
      if (take_instr) begin
        instr_q <= instr;
        simd_q <= second_element_enable;
      end
    end
  end

  // Memory transfers: one index, two values in SIMD mode
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      xfer_q <= '0;
      xfer_pend_q <= 1'b0;
      mem_rd_q <= 1'b0;
    end else begin
      xfer_pend_q <= mem_xfer_valid;
      mem_rd_q <= mem_xfer_valid && !mem_xfer.wr_en;
      if (mem_xfer_valid) begin
        xfer_q <= mem_xfer;
      end
    end
  end

  wire [FILE_AW-1:0] rd_a_addr = reg_addr(instr_q.alt_bank, instr_q.src_a);
  wire [FILE_AW-1:0] rd_b_addr = reg_addr(instr_q.alt_bank, instr_q.src_b);
  wire [FILE_AW-1:0] rd_m_addr = reg_addr(1'b0, mem_xfer.addr);
  wire [FILE_AW-1:0] alu_wa = reg_addr(instr_q.alt_bank, instr_q.alu_dst);
  wire [FILE_AW-1:0] sec_wa = reg_addr(instr_q.alt_bank, instr_q.sec_dst);
  wire [FILE_AW-1:0] mem_wa = reg_addr(1'b0, xfer_q.addr);
  wire mem_wr = xfer_pend_q && xfer_q.wr_en;
  wire alu_wr = exec_now && (instr_q.alu_op != ALU_NOP);
  wire sec_wr = exec_now && (instr_q.sec_op != SEC_NONE);

  logic [DATA_W-1:0] op_a [NUM_ELEM];
  logic [DATA_W-1:0] op_b [NUM_ELEM];
  logic [DATA_W-1:0] rd_m [NUM_ELEM];
  logic [DATA_W-1:0] alu_r [NUM_ELEM];
  logic [DATA_W-1:0] sec_r [NUM_ELEM];
  logic [NUM_ELEM-1:0] elem_on;

  // Element 0 is the primary one and never idles; element 1 gated by mode
  assign elem_on[0] = 1'b1;
  assign elem_on[1] = simd_q;
  assign simd_active = simd_q;

  // Both elements share one decoded instruction, each with its own file
  for (genvar e = 0; e < NUM_ELEM; e++) begin : g_elem
    logic [2:0] wr_en;
    logic [FILE_AW-1:0] wr_addr [3];
    logic [DATA_W-1:0] wr_data [3];
    logic [DATA_W-1:0] mem_word;
    logic mem_on;

    // A transfer in single mode touches only the primary element
    assign mem_on = (e == 0) ? 1'b1 : second_element_enable;
    assign mem_word = (e == 0) ? xfer_q.data : mem_wr_pair.y;
    assign alu_r[e] = alu_fn(instr_q.alu_op, instr_q.fmt, op_a[e], op_b[e]);
    assign sec_r[e] = sec_fn(instr_q.sec_op, instr_q.fmt, op_a[e], op_b[e],
                             instr_q.shamt);
    assign wr_en = {mem_wr && mem_on,
                    sec_wr && elem_on[e],
                    alu_wr && elem_on[e]};
    assign wr_addr[0] = alu_wa;
    assign wr_addr[1] = sec_wa;
    assign wr_addr[2] = mem_wa;
    assign wr_data[0] = alu_r[e];
    assign wr_data[1] = sec_r[e];
    assign wr_data[2] = mem_word;

    elem_regfile u_rf (
      .sys_clk(sys_clk),
      .reset(reset),
      .rd_a_addr(rd_a_addr),
      .rd_b_addr(rd_b_addr),
      .rd_m_addr(rd_m_addr),
      .rd_a_data(op_a[e]),
      .rd_b_data(op_b[e]),
      .rd_m_data(rd_m[e]),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data)
    );
  end

  // Results registered; the secondary lane holds its value when disabled
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      alu_result <= '0;
      sec_result <= '0;
      result_valid <= 1'b0;
    end else begin
      result_valid <= exec_now;
      if (exec_now) begin
        alu_result.x <= alu_r[0];
        sec_result.x <= sec_r[0];
        if (elem_on[1]) begin
          alu_result.y <= alu_r[1];
          sec_result.y <= sec_r[1];
        end
      end
    end
  end

  // Memory lane gate follows the live enable, unlike the instruction lane
  function automatic logic simd_active_rd(input logic en);
    return en;
  endfunction

  // Register-file reads toward memory: both lanes in SIMD, y zero otherwise
  assign mem_rd_pair_valid = mem_rd_q;
  assign mem_rd_pair.x = rd_m[0];
  assign mem_rd_pair.y = simd_active_rd(second_element_enable) ? rd_m[1] : REG_RESET;
endmodule

// >>> tb/simd_datapath_monitor.sv
// Port checker for the dual-element datapath.
// Assumes it is bound onto simd_datapath and sees only its ports.
module simd_datapath_monitor
  import simd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic second_element_enable,
  input wire logic instr_valid,
  input mem_xfer_t mem_xfer,
  input wire logic mem_xfer_valid,
  input pair_t mem_rd_pair,
  input wire logic mem_rd_pair_valid,
  input pair_t alu_result,
  input wire logic result_valid,
  input wire logic simd_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Result pulse is set two edges after the taking edge, so the check sees it at the third
  AST_RES_LAT: assert property (result_valid |-> $past(instr_valid, 3))
    else $error("result without instruction");
  AST_RES_PULSE: assert property (result_valid |=> !result_valid)
    else $error("result pulse too long");
  AST_RD_LAT: assert property (mem_xfer_valid && !mem_xfer.wr_en |=> mem_rd_pair_valid)
    else $error("read answer missing");
  AST_RD_CAUSE: assert property (mem_rd_pair_valid |-> $past(mem_xfer_valid))
    else $error("read answer without request");
  // Secondary lane of a read is gated by the live enable
  AST_Y_GATED: assert property (!second_element_enable |-> mem_rd_pair.y == '0)
    else $error("secondary lane read while disabled");
  AST_MODE: assert property (result_valid |-> simd_active == $past(second_element_enable, 3))
    else $error("mode of result wrong");
  AST_Y_HOLD: assert property (result_valid && !simd_active |-> $stable(alu_result.y))
    else $error("secondary result moved outside mode");
  AST_HOLD: assert property (!result_valid |-> $stable(alu_result))
    else $error("result moved without instruction");
endmodule

bind simd_datapath simd_datapath_monitor i_simd_datapath_monitor (.sys_clk, .reset,
  .second_element_enable, .instr_valid, .mem_xfer, .mem_xfer_valid, .mem_rd_pair,
  .mem_rd_pair_valid, .alu_result, .result_valid, .simd_active);

// >>> tb/data_mem_model.sv
// Data memory model feeding the secondary lane of register writes.
// Assumes the bench drives requests; y data follows one cycle after a write.
module data_mem_model
  import simd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic mem_xfer_valid,
  input mem_xfer_t mem_xfer,
  input wire logic [DATA_W-1:0] y_data,
  output pair_t mem_wr_pair
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_q;
  logic [DATA_W-1:0] y_q;
  // Latch lane data at the taking edge
  always_ff @(posedge sys_clk) begin
    wr_q <= mem_xfer_valid && mem_xfer.wr_en;
    if (mem_xfer_valid && mem_xfer.wr_en) y_q <= y_data;
  end
  // Outside the write cycle show the inverse, so stale data never passes
  assign mem_wr_pair.x = '0;
  assign mem_wr_pair.y = wr_q ? y_q : ~y_q;
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the dual-element datapath.
// Assumes the package, design, model and checker are compiled first.
module tb_top import simd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, reset, en, instr_valid, mem_xfer_valid, mem_rd_pair_valid;
  logic result_valid, simd_active;
  instr_t instr;
  mem_xfer_t mem_xfer;
  logic [DATA_W-1:0] ydat;
  pair_t mem_wr_pair, mem_rd_pair, alu_result, sec_result, la, ls;
  // Expected files of both lanes; index is bank times 16 plus register
  logic [DATA_W-1:0] rx [32];
  logic [DATA_W-1:0] ry [32];
  int fail_count = 0;
  int checks_done = 0;

  simd_datapath i_simd_datapath (.sys_clk, .reset, .second_element_enable(en), .instr_valid,
    .instr, .mem_xfer, .mem_xfer_valid, .mem_wr_pair, .mem_rd_pair, .mem_rd_pair_valid,
    .alu_result, .sec_result, .result_valid, .simd_active);
  data_mem_model i_data_mem_model (.sys_clk, .mem_xfer_valid, .mem_xfer, .y_data(ydat),
    .mem_wr_pair);

  always #5 sys_clk = ~sys_clk;

  task automatic chk(input logic [2*DATA_W-1:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Format masks as the package defines them; operands stay 16 bits wide
  function automatic logic [DATA_W-1:0] alu_f(alu_op_t op, fmt_t f, logic [DATA_W-1:0] a, b);
    logic [DATA_W-1:0] r;
    case (op)
      ALU_ADD: r = a + b;
      ALU_SUB: r = a - b;
      ALU_AND: r = a & b;
      ALU_OR: r = a | b;
      ALU_XOR: r = a ^ b;
      default: r = a;
    endcase
    if (f == FMT_FIXED) return r & FIX_MASK;
    if (f == FMT_SINGLE) return r & SP_MASK;
    return r;
  endfunction

  // Multiply or shift; a 16-bit operand shifted by under 16 never leaves 32 bits
  function automatic logic [DATA_W-1:0] sec_f(sec_op_t op, fmt_t f, logic [DATA_W-1:0] a, b,
                                              int sh);
    logic [DATA_W-1:0] p;
    p = a * b;
    case (op)
      SEC_SHL: return a << sh;
      SEC_SHR: return a >> sh;
      default: return (f == FMT_FIXED) ? (p & FIX_MASK) : p;
    endcase
  endfunction

  // One transfer; for a read, x and y are the expected lanes
  task automatic mem(input logic wr, input int r, input logic [DATA_W-1:0] x, y);
    mem_xfer_valid = 1;
    mem_xfer = '{wr, r[3:0], x};
    ydat = y;
    @(posedge sys_clk) #1;
    mem_xfer_valid = 0;
    if (!wr) begin
      chk(mem_rd_pair_valid, 1);
      chk(mem_rd_pair, {x, y});
    end
    @(posedge sys_clk) #1;
  endtask

  // ALU with a multiply or shift; the second result lands four registers higher
  task automatic exec(input alu_op_t op, input sec_op_t so, input fmt_t f, input logic bk,
                      input int a, b, d, sh);
    int o;
    o = bk ? 16 : 0;
    instr_valid = 1;
    instr = '{op, so, f, bk, a[3:0], b[3:0], d[3:0], d[3:0] + 4'h4, sh[5:0]};
    @(posedge sys_clk) #1;
    instr_valid = 0;
    repeat (2) @(posedge sys_clk);
    #1;
    la.x = alu_f(op, f, rx[o+a], rx[o+b]);
    ls.x = sec_f(so, f, rx[o+a], rx[o+b], sh);
    rx[o+d] = la.x;
    rx[o+d+4] = ls.x;
    if (en) begin
      la.y = alu_f(op, f, ry[o+a], ry[o+b]);
      ls.y = sec_f(so, f, ry[o+a], ry[o+b], sh);
      ry[o+d] = la.y;
      ry[o+d+4] = ls.y;
    end
    chk(result_valid, 1);
    chk(simd_active, en);
    chk(alu_result, la);
    chk(sec_result, ls);
    @(posedge sys_clk) #1;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    sys_clk = 0;
    reset = 1;
    en = 1;
    instr_valid = 0;
    instr = '0;
    mem_xfer = '0;
    mem_xfer_valid = 0;
    ydat = '0;
    la = '0;
    ls = '0;
    void'($urandom(59077));
    repeat (6) @(posedge sys_clk);
    #1;
    reset = 0;
    chk(alu_result, '0);
    // Primary bank loaded through memory; secondary bank keeps its reset value
    for (int i = 0; i < 16; i++) begin
      rx[i] = $urandom() & 40'h00_0000_FFFF;
      ry[i] = $urandom() & 40'h00_0000_FFFF;
      rx[i+16] = REG_RESET;
      ry[i+16] = REG_RESET;
      mem(1, i, rx[i], ry[i]);
    end
    // Disabled secondary element must keep its register
    en = 0;
    rx[0] = 40'h00_0000_1234;
    mem(1, 0, rx[0], 40'h00_0000_ABCD);
    mem(0, 0, rx[0], '0);
    en = 1;
    mem(0, 0, rx[0], ry[0]);
    // Every ALU op without and with the second element, formats and shifts mixed;
    // the last two use the secondary bank, still at reset, to tell the banks apart
    for (int k = 0; k < 14; k++) begin
      en = (k >= 6);
      exec(alu_op_t'(1 + k % 6), sec_op_t'(1 + k % 3), fmt_t'((k / 2) % 3), k >= 12,
           $urandom_range(7), $urandom_range(7), 8 + k % 4, $urandom_range(15));
    end
    for (int i = 0; i < 16; i++) mem(0, i, rx[i], ry[i]);
    print_verdict();
  end

  // Cut a hang short; the sequence needs well under 2000 cycles
  initial begin
    #20000;
    fail_count++;
    print_verdict();
  end
endmodule
